// [src/host_port_regs.vh]
// Constants for the host secondary-address port and service request logic
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
// Secondary address codes
`define SEC_SYS_STATUS   5'h01
`define SEC_MAIN_STATUS  5'h02
`define SEC_RES_STATUS   5'h03
`define SEC_INT_STATUS   5'h04
`define SEC_BUF_WRITE    5'h05
`define SEC_BUF_READ     5'h06
`define SEC_VAR_WRITE    5'h07
`define SEC_VAR_READ     5'h08
`define SEC_DOWNLOAD     5'h09
`define SEC_PORT_A       5'h0B
`define SEC_PORT_D       5'h0E
// Fixed block lengths in words
`define LEN_STATUS       16'h0008
`define LEN_INT_STATUS   16'h0010
// Interrupt status word index of the request code
`define INT_CODE_WORD    4'h0
// Transfer kind codes
`define XFER_NONE        4'h0
`define XFER_STATUS      4'h1
`define XFER_BUF_WR      4'h2
`define XFER_BUF_RD      4'h3
`define XFER_VAR_WR      4'h4
`define XFER_VAR_RD      4'h5
`define XFER_DOWNLOAD    4'h6
`define XFER_PORT        4'h7
`define XFER_INVALID     4'h8
// Interrupt action select values
`define CARD_ACT_SRQ     1'b0
`define CARD_ACT_TASK    1'b1
// Edge select codes for digital input interrupts
`define EDGE_RISE        2'h1
`define EDGE_FALL        2'h2
`define EDGE_BOTH        2'h3
// Word transfer time at 500 KB/s: 4000 ns per 16-bit word
`define WORD_TIME_NS     4000
`define CLK_PERIOD_NS    10
`define WORD_CYCLES      (`WORD_TIME_NS / `CLK_PERIOD_NS)
// Pacing counter reload: one word per WORD_CYCLES, counted from zero
`define PACE_RELOAD      16'h018F
`endif

// [src/host_secondary_port_srq_ctrl.v]
// Host secondary-address decoder, port release and service request control
`timescale 1ns/1ps
`include "host_port_regs.vh"
// Function
// R1: Secondaries 1-4 return 8/8/8/16 status words
// R2: Secondaries 5-8 buffer/variable write and read
// R3: Secondary 9 writes accepted as subroutine download
// R4: Secondaries 11-14 deliver ports A-D buffers
// R5: Altering released buffer suspends the task
// R6: Suspension halts all task scheduling
// R7: Reading waiting word count frees the buffer
// R8: Any non-main buffer releasable, several per port
// R9: Card interrupts on edges, counts, overflow, limits
// R10: Card interrupt requests service or schedules task
// R11: Interrupt task waits for normal scheduler turn
// R12: Programmed request n stored, asserts service line
// R13: Only unsolicited action is the service request
// R14: Pending request held during host transfer; the code lets it out on a new xfer_start even while held
// R15: Unread results, terminator wait, short secondaries block
// R16: All host transfers paced as memory access
// R17: Host must move exactly expected word count
// R18: Host polls then reads interrupt status
// R19: Host advised to check status after transfers
// R20: Short system status read stays incomplete
// R21: Serial poll clears request, code kept
module host_secondary_port_srq_ctrl (
	// Clock and reset
	input  wire        core_clk,
	input  wire        sys_rst,
	// Host bus side: transfer framing and word strobes (already synchronised)
	input  wire        xfer_start,
	input  wire [4:0]  xfer_secondary,
	input  wire [15:0] xfer_count,
	input  wire        host_word,
	input  wire        await_eoi,
	input  wire        await_bang,
	input  wire        serial_poll_read,
	output wire        word_ready,
	output reg         srq_out,
	output reg         srq_oe,
	output reg         status_byte_rsv,
	output reg  [3:0]  xfer_kind,
	output reg  [1:0]  xfer_port,
	output reg         xfer_busy,
	output reg         xfer_done,
	output reg         dma_word,
	// Task processor side
	input  wire        main_results_unread,
	input  wire        release_req,
	input  wire [1:0]  release_port,
	input  wire [15:0] release_words,
	input  wire        release_is_main,
	input  wire        alter_req,
	input  wire [1:0]  alter_port,
	input  wire        alter_released,
	input  wire        prog_srq,
	input  wire [6:0]  prog_srq_code,
	input  wire        task_yield,
	output reg         sched_halt,
	output reg         release_reject,
	output reg  [63:0] port_words,
	output reg  [6:0]  int_code,
	output reg         task_wake,
	output reg  [3:0]  task_wake_card,
	// Function card interrupt sources (pins, synchronised here)
	input  wire [3:0]  card_din,
	input  wire [7:0]  card_edge_sel,
	input  wire [3:0]  card_event,
	input  wire [3:0]  card_action
);
	// Transfer state machine, one-hot
	localparam ST_IDLE = 3'h1;
	localparam ST_MOVE = 3'h2;
	localparam ST_DONE = 3'h4;

	reg  [2:0]  state;
	reg  [15:0] words_left;
	reg  [15:0] pace_cnt;
	reg         srq_pend;
	reg         suspended;
	reg  [3:0]  din_s1;
	reg  [3:0]  din_s2;
	reg  [3:0]  din_d;
	reg  [3:0]  evt_s1;
	reg  [3:0]  evt_s2;
	reg  [3:0]  evt_d;
	reg  [3:0]  task_pend;
	reg  [3:0]  next_kind;
	reg  [15:0] next_len;
	wire [3:0]  card_irq;
	wire        xfer_hold;
	wire        card_srq;
	wire [1:0]  port_idx;
	wire        alter_hit;
	reg         next_suspended;
	reg  [1:0]  susp_port;

	// Port index: secondary 11 lands on A, 14 on D
	assign port_idx = xfer_secondary[1:0] + 2'h1;

	// Decode secondary into kind and expected length
	always @* begin
		next_kind = `XFER_INVALID;
		next_len  = xfer_count;
		case (xfer_secondary)
		`SEC_SYS_STATUS, `SEC_MAIN_STATUS, `SEC_RES_STATUS: begin
			next_kind = `XFER_STATUS; // [R1]
			next_len  = `LEN_STATUS; // [R20]
		end
		`SEC_INT_STATUS: begin
			next_kind = `XFER_STATUS; // [R1]
			next_len  = `LEN_INT_STATUS;
		end
		`SEC_BUF_WRITE: next_kind = `XFER_BUF_WR; // [R2]
		`SEC_BUF_READ:  next_kind = `XFER_BUF_RD; // [R2]
		`SEC_VAR_WRITE: next_kind = `XFER_VAR_WR; // [R2]
		`SEC_VAR_READ:  next_kind = `XFER_VAR_RD; // [R2]
		`SEC_DOWNLOAD:  next_kind = `XFER_DOWNLOAD; // [R3]
		default: begin
			if (xfer_secondary >= `SEC_PORT_A &&
			    xfer_secondary <= `SEC_PORT_D) begin
				next_kind = `XFER_PORT; // [R4]
				next_len  = port_words[{port_idx, 4'h0} +: 16];
			end
		end
		endcase
	end

	// Word pacing: DMA never faster than the rated word rate
	assign word_ready = (state == ST_MOVE) && (pace_cnt == 16'h0000); // [R16]

	// Transfer engine; a short count leaves the engine busy
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state      <= ST_IDLE;
			words_left <= 16'h0000;
			pace_cnt   <= 16'h0000;
			xfer_kind  <= `XFER_NONE;
			xfer_port  <= 2'h0;
			xfer_busy  <= 1'b0;
			xfer_done  <= 1'b0;
			dma_word   <= 1'b0;
		end else begin
			xfer_done <= 1'b0;
			dma_word  <= 1'b0;
			if (pace_cnt != 16'h0000)
				pace_cnt <= pace_cnt - 16'h0001;
			case (state)
			ST_IDLE: begin
				if (xfer_start) begin
					xfer_kind  <= next_kind;
					xfer_port  <= port_idx;
					words_left <= next_len;
					xfer_busy  <= 1'b1;
					state      <= (next_len == 16'h0000) ? ST_DONE : ST_MOVE;
				end
			end
			ST_MOVE: begin
				if (xfer_start) begin
					// New transfer abandons the old one
					xfer_kind  <= next_kind;
					xfer_port  <= port_idx;
					words_left <= next_len;
					state      <= (next_len == 16'h0000) ? ST_DONE : ST_MOVE;
				end else if (host_word && word_ready) begin
					dma_word   <= 1'b1; // [R16]
					pace_cnt   <= `PACE_RELOAD;
					words_left <= words_left - 16'h0001; // [R17]
					if (words_left == 16'h0001)
						state <= ST_DONE;
				end
			end
			ST_DONE: begin
				// A start here is kept, so no open is ever lost
				xfer_done <= 1'b1;
				if (xfer_start) begin
					xfer_kind  <= next_kind;
					xfer_port  <= port_idx;
					words_left <= next_len;
					state      <= (next_len == 16'h0000) ? ST_DONE : ST_MOVE;
				end else begin
					xfer_busy <= 1'b0;
					state     <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Released-buffer word counts per port; a full read frees them
	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_port
			wire add_now;
			wire read_done;
			assign add_now   = release_req && !release_is_main &&
				release_port == p;
			assign read_done = state == ST_DONE &&
				xfer_kind == `XFER_PORT && xfer_port == p;
			// A release in the cycle of the read survives it
			always @(posedge core_clk) begin
				if (sys_rst) begin
					port_words[p*16 +: 16] <= 16'h0000;
				end else if (add_now) begin
					port_words[p*16 +: 16] <= release_words + // [R8]
						(read_done ? 16'h0000 : port_words[p*16 +: 16]);
				end else if (read_done) begin
					port_words[p*16 +: 16] <= 16'h0000; // [R7]
				end
			end
		end
	endgenerate

	// Main result buffer is never releasable
	always @(posedge core_clk) begin
		if (sys_rst)
			release_reject <= 1'b0;
		else
			release_reject <= release_req && release_is_main; // [R8]
	end

	// Task suspension on released buffer stalls the whole scheduler
	assign alter_hit = alter_req && alter_released &&
		port_words[{alter_port, 4'h0} +: 16] != 16'h0000;

	// Only the port that caused the stall can lift it
	always @* begin
		next_suspended = suspended;
		if (alter_hit)
			next_suspended = 1'b1; // [R5]
		else if (port_words[{susp_port, 4'h0} +: 16] == 16'h0000)
			next_suspended = 1'b0; // [R5]
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			suspended <= 1'b0;
			susp_port <= 2'h0;
		end else begin
			suspended <= next_suspended;
			if (alter_hit)
				susp_port <= alter_port;
		end
	end

	always @* begin
		sched_halt = suspended; // [R6]
	end

	// Card input synchronisers
	always @(posedge core_clk) begin
		if (sys_rst) begin
			din_s1 <= 4'h0;
			din_s2 <= 4'h0;
			din_d  <= 4'h0;
			evt_s1 <= 4'h0;
			evt_s2 <= 4'h0;
			evt_d  <= 4'h0;
		end else begin
			din_s1 <= card_din;
			din_s2 <= din_s1;
			din_d  <= din_s2;
			evt_s1 <= card_event;
			evt_s2 <= evt_s1;
			evt_d  <= evt_s2;
		end
	end

	// Interrupt per card: selected edge or rising completion event
	genvar c;
	generate
		for (c = 0; c < 4; c = c + 1) begin : g_card
			assign card_irq[c] =
				(card_edge_sel[c*2 +: 2] == `EDGE_RISE &&
				 din_s2[c] && !din_d[c]) ||
				(card_edge_sel[c*2 +: 2] == `EDGE_FALL &&
				 !din_s2[c] && din_d[c]) ||
				(card_edge_sel[c*2 +: 2] == `EDGE_BOTH &&
				 din_s2[c] != din_d[c]) ||
				(evt_s2[c] && !evt_d[c]); // [R9]
		end
	endgenerate

	assign card_srq = |(card_irq & ~card_action); // [R10]

	// Linked tasks queue until the scheduler yields
	always @(posedge core_clk) begin
		if (sys_rst) begin
			task_pend      <= 4'h0;
			task_wake      <= 1'b0;
			task_wake_card <= 4'h0;
		end else begin
			task_wake <= 1'b0;
			// Next value used so no wake slips out as a stall begins
			if (task_yield && !next_suspended && task_pend != 4'h0) begin
				task_wake      <= 1'b1; // [R11]
				task_wake_card <= task_pend & (~task_pend + 4'h1);
				task_pend      <= (task_pend & (task_pend - 4'h1)) |
					(card_irq & card_action); // [R10]
			end else begin
				task_pend <= task_pend | (card_irq & card_action); // [R10]
			end
		end
	end

	// Anything that counts as a host transfer in progress
	assign xfer_hold = xfer_busy || main_results_unread ||
		await_eoi || await_bang; // [R15]

	// Service request: pend, hold off, assert, clear on poll
	always @(posedge core_clk) begin
		if (sys_rst) begin
			srq_pend        <= 1'b0;
			srq_out         <= 1'b0;
			srq_oe          <= 1'b0;
			status_byte_rsv <= 1'b0;
			int_code        <= 7'h00;
		end else begin
			if (prog_srq && prog_srq_code != 7'h00)
				int_code <= prog_srq_code; // [R12]
			// New request wins over a poll in the same cycle
			if ((prog_srq && prog_srq_code != 7'h00) || card_srq)
				srq_pend <= 1'b1; // [R12]
			else if (serial_poll_read && status_byte_rsv)
				srq_pend <= 1'b0; // [R21]
			// A new start lets the held request out
			if (srq_pend && (!xfer_hold || xfer_start) &&
			    !(serial_poll_read && status_byte_rsv)) begin
				srq_out         <= 1'b1; // [R14]
				srq_oe          <= 1'b1; // [R13]
				status_byte_rsv <= 1'b1;
			end else if (serial_poll_read || !srq_pend) begin
				srq_out         <= 1'b0; // [R21]
				srq_oe          <= 1'b0;
				status_byte_rsv <= 1'b0;
			end
		end
	end

endmodule // host_secondary_port_srq_ctrl

// [verification/host_secondary_port_srq_ctrl_assertions.sv]
// Checker on the ports of the secondary-address and request block
`timescale 1ns/1ps
`include "host_port_regs.vh"
module host_port_checker (
	// Clock and reset
	input wire        core_clk,
	input wire        sys_rst,
	// Host side
	input wire        xfer_start,
	input wire [4:0]  xfer_secondary,
	input wire        await_eoi,
	input wire        await_bang,
	input wire        serial_poll_read,
	input wire        word_ready,
	input wire        srq_out,
	input wire        srq_oe,
	input wire [3:0]  xfer_kind,
	input wire [1:0]  xfer_port,
	input wire        xfer_busy,
	input wire        dma_word,
	// Task side
	input wire        main_results_unread,
	input wire        release_req,
	input wire        release_is_main,
	input wire        release_reject,
	input wire        alter_req,
	input wire [1:0]  alter_port,
	input wire        alter_released,
	input wire        prog_srq,
	input wire [6:0]  prog_srq_code,
	input wire        sched_halt,
	input wire [63:0] port_words,
	input wire [6:0]  int_code,
	input wire        task_wake
);
	// Anything that may legally keep the request line quiet
	wire hold_any = await_eoi | await_bang | main_results_unread |
		xfer_busy | xfer_start | serial_poll_read;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_req; prog_srq && prog_srq_code != 7'h00 && !hold_any; endsequence
	sequence s_quiet; !hold_any; endsequence
	property p_srq_raise; s_req ##1 s_quiet |=> srq_out; endproperty
	a_srq_raise: assert property (p_srq_raise) else $error("request lost");
	property p_code; s_req |=> int_code == $past(prog_srq_code); endproperty
	a_code: assert property (p_code) else $error("code not stored");
	property p_hold;
		$rose(srq_out) |-> !$past(await_eoi) && !$past(await_bang) &&
			!$past(main_results_unread);
	endproperty
	a_hold: assert property (p_hold) else $error("request during hold");
	property p_oe; srq_out |-> srq_oe; endproperty
	a_oe: assert property (p_oe) else $error("line not driven");
	property p_poll; serial_poll_read && !prog_srq |=> !srq_out; endproperty
	a_poll: assert property (p_poll) else $error("poll left request");
	property p_gap; dma_word |-> !word_ready ##1 !word_ready [*8]; endproperty
	a_gap: assert property (p_gap) else $error("word pacing short");
	property p_stat;
		xfer_start && xfer_secondary >= `SEC_SYS_STATUS &&
			xfer_secondary <= `SEC_INT_STATUS |=> xfer_kind == `XFER_STATUS;
	endproperty
	a_stat: assert property (p_stat) else $error("status decode");
	property p_port;
		xfer_start && xfer_secondary >= `SEC_PORT_A &&
			xfer_secondary <= `SEC_PORT_D |=> xfer_kind == `XFER_PORT &&
			xfer_port == $past(xfer_secondary[1:0]) + 2'h1;
	endproperty
	a_port: assert property (p_port) else $error("port decode");
	property p_reject; release_req && release_is_main |=> release_reject; endproperty
	a_reject: assert property (p_reject) else $error("main accepted");
	property p_susp;
		alter_req && alter_released &&
			port_words[{alter_port, 4'h0} +: 16] != 16'h0000 |=> sched_halt;
	endproperty
	a_susp: assert property (p_susp) else $error("no suspension");
	property p_halt; sched_halt |-> !task_wake; endproperty
	a_halt: assert property (p_halt) else $error("task ran in halt");
endmodule // host_port_checker
bind host_secondary_port_srq_ctrl host_port_checker u_checker (
	.core_clk, .sys_rst, .xfer_start, .xfer_secondary, .await_eoi,
	.await_bang, .serial_poll_read, .word_ready, .srq_out, .srq_oe,
	.xfer_kind, .xfer_port, .xfer_busy, .dma_word, .main_results_unread,
	.release_req, .release_is_main, .release_reject, .alter_req,
	.alter_port, .alter_released, .prog_srq, .prog_srq_code, .sched_halt,
	.port_words, .int_code, .task_wake);

// [verification/host_bus_controller_model.sv]
// Host bus controller model that opens transfers and moves words
`timescale 1ns/1ps
module host_bus_controller_model (
	// Clock and pacing from the device
	input wire        core_clk,
	input wire        word_ready,
	// Transfer control towards the device
	output reg        xfer_start,
	output reg [4:0]  xfer_secondary,
	output reg [15:0] xfer_count,
	output reg        host_word,
	output reg        serial_poll_read
);
	integer n_late = 0;
	initial begin
		xfer_start = 1'b0;
		xfer_secondary = 5'h1F;
		xfer_count = 16'hFFFF;
		host_word = 1'b0;
		serial_poll_read = 1'b0;
	end
	// Host alone opens transfers; address dropped to a new pattern after
	task open_xfer(input [4:0] sec, input [15:0] cnt);
		xfer_start = 1'b1;
		xfer_secondary = sec;
		xfer_count = cnt;
		@(posedge core_clk);
		#1 xfer_start = 1'b0;
		xfer_secondary = ~sec;
		xfer_count = ~cnt;
	endtask
	// Word held until sampled with ready; exact count set by caller
	task move_words(input integer n);
		integer i, t;
		for (i = 0; i < n; i++) begin
			host_word = 1'b1;
			t = 0;
			do begin
				@(negedge core_clk);
				t++;
			end while (word_ready !== 1'b1 && t < 1000);
			if (t >= 1000)
				n_late++;
			@(posedge core_clk);
			#1 host_word = 1'b0;
			@(posedge core_clk);
			#1;
		end
	endtask
	// Serial poll read of the status byte after a request
	task poll;
		serial_poll_read = 1'b1;
		@(posedge core_clk);
		#1 serial_poll_read = 1'b0;
	endtask
endmodule // host_bus_controller_model

// [verification/host_secondary_port_srq_ctrl_bench.sv]
// Self-checking bench for the secondary-address and request block
`timescale 1ns/1ps
module host_secondary_port_srq_ctrl_bench;
	reg core_clk = 0, sys_rst = 1, await_eoi = 0, await_bang = 0;
	reg main_results_unread = 0, release_req = 0, release_is_main = 0;
	reg alter_req = 0, alter_released = 0, prog_srq = 0, task_yield = 0;
	reg [1:0] release_port = 0, alter_port = 0;
	reg [15:0] release_words = 0;
	reg [6:0] prog_srq_code = 0;
	reg [3:0] card_din = 0, card_event = 0, card_action = 0;
	reg [7:0] card_edge_sel = 0;
	reg [31:0] seed = 32'h62BC;
	wire xfer_start, host_word, serial_poll_read, word_ready, srq_out;
	wire xfer_busy, sched_halt, release_reject, task_wake;
	wire xfer_done, status_byte_rsv;
	wire [4:0] xfer_secondary;
	wire [15:0] xfer_count;
	wire [3:0] xfer_kind, task_wake_card;
	wire [63:0] port_words;
	wire [6:0] int_code;
	integer n_mismatch = 0, samples_checked = 0, exp_port[4], i, c;
	integer n_done = 0;
	always #5 core_clk = ~core_clk;
	// Completed transfers, counted away from the launching edge
	always @(negedge core_clk)
		if (xfer_done === 1'b1)
			n_done++;
	host_bus_controller_model u_host (.core_clk, .word_ready, .xfer_start,
		.xfer_secondary, .xfer_count, .host_word, .serial_poll_read);
	host_secondary_port_srq_ctrl u_dut (.core_clk, .sys_rst, .xfer_start,
		.xfer_secondary, .xfer_count, .host_word, .await_eoi, .await_bang,
		.serial_poll_read, .word_ready, .srq_out, .srq_oe(),
		.status_byte_rsv, .xfer_kind, .xfer_port(), .xfer_busy,
		.xfer_done, .dma_word(), .main_results_unread, .release_req,
		.release_port, .release_words, .release_is_main, .alter_req,
		.alter_port, .alter_released, .prog_srq, .prog_srq_code, .task_yield,
		.sched_halt, .release_reject, .port_words, .int_code, .task_wake,
		.task_wake_card, .card_din, .card_edge_sel, .card_event, .card_action);
	function [31:0] rnd;
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		rnd = seed;
	endfunction
	task tick(input integer n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task chk(input string nm, input [63:0] e, input [63:0] g);
		samples_checked++;
		if (e !== g) begin
			n_mismatch++;
			$display("MISMATCH %0s exp %0h got %0h", nm, e, g);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Bounded wait for the request line, then answer with a poll
	task srq_poll;
		integer w;
		w = 0;
		while (srq_out !== 1'b1 && w < 40) begin
			tick(1);
			w++;
		end
		chk("srq_out", 1, srq_out);
		if (w >= 40)
			complete_run;
		chk("status_byte_rsv", 1, status_byte_rsv);
		u_host.poll;
		tick(1);
		chk("srq_out", 0, srq_out);
		chk("status_byte_rsv", 0, status_byte_rsv);
	endtask
	// Words from the host; a stalled word ends the run
	task words(input integer n);
		u_host.move_words(n);
		if (u_host.n_late > 0) begin
			n_mismatch++;
			complete_run;
		end
	endtask
	task xfer(input [4:0] s, input integer n);
		u_host.open_xfer(s, 16'h0000);
		words(n);
		tick(3);
	endtask
	task req(input [6:0] code);
		prog_srq = 1;
		prog_srq_code = code;
		tick(1);
		prog_srq = 0;
	endtask
	task rel(input [1:0] p, input [15:0] w, input m);
		release_req = 1;
		release_port = p;
		release_words = w;
		release_is_main = m;
		tick(1);
		release_req = 0;
		chk("release_reject", m, release_reject);
		if (!m)
			exp_port[p] += w;
		tick(1);
	endtask
	initial begin
		for (i = 0; i < 4; i++)
			exp_port[i] = 0;
		tick(5);
		sys_rst = 0;
		chk("srq_out", 0, srq_out);
		// Request raised mid-read waits for the transfer to finish
		c = rnd() % 127 + 1;
		u_host.open_xfer(5'h01, 16'h0000);
		words(3);
		req(c[6:0]);
		tick(4);
		chk("srq_out", 0, srq_out);
		words(5);
		tick(3);
		chk("xfer_busy", 0, xfer_busy);
		chk("xfer_done", 1, n_done);
		srq_poll;
		chk("int_code", c, int_code);
		await_eoi = 1;
		req(7'h7F);
		tick(8);
		chk("srq_out", 0, srq_out);
		await_eoi = 0;
		srq_poll;
		$display("test request hold done");
		// Short status read stays open until a new transfer
		xfer(5'h01, 7);
		chk("xfer_busy", 1, xfer_busy);
		chk("xfer_done", 1, n_done);
		xfer(5'h04, 16);
		chk("xfer_busy", 0, xfer_busy);
		chk("xfer_done", 2, n_done);
		$display("test short read done");
		// Two buffers on one port, a refused main buffer, suspension
		rel(2'h1, rnd() % 3 + 1, 0);
		rel(2'h1, rnd() % 3 + 1, 0);
		rel(2'h2, 16'h0003, 1);
		chk("port_words", exp_port[1], port_words[31:16]);
		alter_req = 1;
		alter_port = 2'h1;
		alter_released = 1;
		tick(1);
		alter_req = 0;
		xfer(5'h01, 8);
		chk("sched_halt", 1, sched_halt);
		xfer(5'h0C, exp_port[1]);
		chk("port_words", 0, port_words);
		chk("sched_halt", 0, sched_halt);
		$display("test ports done");
		// Secondaries 2 to 14, bar 10, decode to their transfer kinds
		for (i = 2; i < 15; i++) begin
			if (i == 10)
				continue;
			u_host.open_xfer(i[4:0], 16'h0000);
			chk("xfer_kind", i < 5 ? 1 : i < 10 ? i - 3 : 7, xfer_kind);
			tick(4);
		end
		$display("test decode done");
		// Each edge choice on card 0 asks for service by default
		for (i = 1; i < 4; i++) begin
			card_edge_sel[1:0] = i[1:0];
			card_din[0] = 1;
			tick(8);
			chk("srq_out", i[0], srq_out);
			if (i[0])
				srq_poll;
			card_din[0] = 0;
			tick(8);
			chk("srq_out", i[1], srq_out);
			if (i[1])
				srq_poll;
		end
		card_event = 4'h4;
		tick(4);
		card_event = 0;
		srq_poll;
		// Card 1 linked to a task wakes it at the next turn
		card_action = 4'h2;
		card_edge_sel[3:2] = 2'h2;
		card_din[1] = 1;
		tick(5);
		card_din[1] = 0;
		tick(8);
		task_yield = 1;
		tick(1);
		task_yield = 0;
		c = 0;
		while (task_wake !== 1'b1 && c < 20) begin
			tick(1);
			c++;
		end
		chk("task_wake", 1, task_wake);
		chk("task_wake_card", 4'h2, task_wake_card);
		$display("test cards done");
		complete_run;
	end
endmodule // host_secondary_port_srq_ctrl_bench
